// >>> verilog/vdc_ctrl_regs.v
// decoder control register bank behind the two-wire host port
`timescale 1ns/1ns
`default_nettype none
`include "vdc_regs.vh"
module vdc_ctrl_regs (
  input wire clock_in,
  input wire rst_n_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n_out,
  input wire embedded_format_in,
  output reg [7:0] input_routing_out,
  output reg auto_luma_gain_out,
  output reg auto_chroma_gain_out,
  output reg frontend_gain_freeze_out,
  output reg [2:0] standard_out,
  output reg autoswitch_on_out,
  output reg standard_reserved_out,
  output reg settings_reinit_out,
  output reg proc_clock_slow_out,
  output reg adc_power_down_out,
  output reg [6:0] autodetect_mask_out,
  output reg color_kill_auto_out,
  output reg color_kill_force_out,
  output reg [4:0] color_kill_threshold_out,
  output reg pedestal_present_out,
  output reg raw_vbi_out,
  output reg [3:0] luma_delay_out,
  output reg [1:0] luma_filter_out,
  output reg [1:0] peaking_gain_out,
  output reg [1:0] trap_filter_out,
  output reg [7:0] brightness_out,
  output reg [7:0] contrast_out,
  output reg [7:0] saturation_out,
  output reg [7:0] hue_out,
  output reg [1:0] chroma_gain_mode_out,
  output reg color_pll_reset_out,
  output reg chroma_comb_on_out,
  output reg pal_comp_out,
  output reg wideband_chroma_lowpass_out,
  output reg [1:0] chroma_notch_out,
  output reg [9:0] active_video_start_out,
  output reg active_video_flag_vblank_off_out
);
  // ---------------------------------------------------------------
  // host port state machine
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_DEV = 3'd1;
  localparam [2:0] ST_ACK = 3'd2;
  localparam [2:0] ST_SUB = 3'd3;
  localparam [2:0] ST_WR = 3'd4;
  localparam [2:0] ST_RD = 3'd5;
  localparam [2:0] ST_RACK = 3'd6;

  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;
  reg [2:0] state_q;
  reg [2:0] next_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] sub_q;
  reg [7:0] rdata_q;
  reg [7:0] av_lo_stage_q;
  reg [7:0] std_prev_q;
  reg av_init_q;
  wire start_cond;
  wire stop_cond;
  wire byte_done;
  wire wr_stb;

  vdc_pin_edge u_scl (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pin_in(scl_in),
    .level_out(scl_lvl),
    .rise_out(scl_rise),
    .fall_out(scl_fall)
  );

  vdc_pin_edge u_sda (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pin_in(sda_in),
    .level_out(sda_lvl),
    .rise_out(sda_rise),
    .fall_out(sda_fall)
  );

  assign start_cond = sda_fall & scl_lvl;
  assign stop_cond = sda_rise & scl_lvl;
  assign byte_done = scl_fall & (bit_cnt_q == 4'd8);
  assign wr_stb = byte_done & (state_q == ST_WR);

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      next_q <= ST_IDLE;
      bit_cnt_q <= 4'd0;
      shift_q <= 8'h00;
      sub_q <= 8'h00;
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1;
    end else if (start_cond) begin
      state_q <= ST_DEV;
      bit_cnt_q <= 4'd0;
      sda_oe_n_out <= 1'b1;
    end else if (stop_cond) begin
      state_q <= ST_IDLE;
      sda_oe_n_out <= 1'b1;
    end else begin
      case (state_q)
        ST_DEV, ST_SUB, ST_WR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_lvl};
            bit_cnt_q <= bit_cnt_q + 4'd1;
          end else if (byte_done) begin
            bit_cnt_q <= 4'd0;
            state_q <= ST_ACK;
            sda_oe_n_out <= 1'b0;
            if (state_q == ST_DEV) begin
              if (shift_q[7:1] != `VDC_DEV_ADDR) begin
                state_q <= ST_IDLE;
                sda_oe_n_out <= 1'b1;
              end
              next_q <= shift_q[0] ? ST_RD : ST_SUB;
            end else if (state_q == ST_SUB) begin
              sub_q <= shift_q;
              next_q <= ST_WR;
            end else begin
              sub_q <= sub_q + 8'h01;
              next_q <= ST_WR;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state_q <= next_q;
            if (next_q == ST_RD) begin
              shift_q <= rdata_q;
              sda_oe_n_out <= rdata_q[7];
              bit_cnt_q <= 4'd1;
              sub_q <= sub_q + 8'h01;
            end else begin
              sda_oe_n_out <= 1'b1;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_cnt_q == 4'd8) begin
              sda_oe_n_out <= 1'b1;
              state_q <= ST_RACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe_n_out <= shift_q[6];
              bit_cnt_q <= bit_cnt_q + 4'd1;
            end
          end
        end
        ST_RACK: begin
          // a not-acknowledge from the controller ends the read burst
          if (scl_rise) begin
            state_q <= sda_lvl ? ST_IDLE : ST_ACK;
            next_q <= ST_RD;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  wire [7:0] r_route;
  wire [7:0] r_gain;
  wire [7:0] r_std;
  wire [7:0] r_pwr;
  wire [7:0] r_mask;
  wire [7:0] r_kill;
  wire [7:0] r_luma_a;
  wire [7:0] r_luma_b;
  wire [7:0] r_trap;
  wire [7:0] r_bright;
  wire [7:0] r_contr;
  wire [7:0] r_sat;
  wire [7:0] r_hue;
  wire [7:0] r_chr_a;
  wire [7:0] r_chr_b;
  wire [7:0] r_av_hi;

`define VDC_BYTE(inst, val, ofs, rv, mk) \
  vdc_byte_reg #(.RESET_VAL(rv), .WR_MASK(mk)) inst ( \
    .clock_in(clock_in), .rst_n_in(rst_n_in), \
    .we_in(wr_stb && (sub_q == ofs)), .data_in(shift_q), .value_out(val));

  `VDC_BYTE(u_route, r_route, `VDC_OFS_ROUTE, `VDC_RST_ROUTE, `VDC_MSK_FULL)
  `VDC_BYTE(u_gain, r_gain, `VDC_OFS_GAIN, `VDC_RST_GAIN, `VDC_MSK_GAIN)
  `VDC_BYTE(u_std, r_std, `VDC_OFS_STD, `VDC_RST_STD, `VDC_MSK_STD)
  `VDC_BYTE(u_pwr, r_pwr, `VDC_OFS_PWR, `VDC_RST_PWR, `VDC_MSK_PWR)
  `VDC_BYTE(u_mask, r_mask, `VDC_OFS_MASK, `VDC_RST_MASK, `VDC_MSK_MASK)
  `VDC_BYTE(u_kill, r_kill, `VDC_OFS_KILL, `VDC_RST_KILL, `VDC_MSK_KILL)
  `VDC_BYTE(u_luma_a, r_luma_a, `VDC_OFS_LUMA_A, `VDC_RST_LUMA_A, `VDC_MSK_LUMA_A)
  `VDC_BYTE(u_luma_b, r_luma_b, `VDC_OFS_LUMA_B, `VDC_RST_LUMA_B, `VDC_MSK_LUMA_B)
  `VDC_BYTE(u_trap, r_trap, `VDC_OFS_TRAP, `VDC_RST_TRAP, `VDC_MSK_TRAP)
  `VDC_BYTE(u_bright, r_bright, `VDC_OFS_BRIGHT, `VDC_RST_LEVEL, `VDC_MSK_FULL)
  `VDC_BYTE(u_contr, r_contr, `VDC_OFS_CONTR, `VDC_RST_LEVEL, `VDC_MSK_FULL)
  `VDC_BYTE(u_sat, r_sat, `VDC_OFS_SAT, `VDC_RST_LEVEL, `VDC_MSK_FULL)
  `VDC_BYTE(u_hue, r_hue, `VDC_OFS_HUE, `VDC_RST_HUE, `VDC_MSK_FULL)
  `VDC_BYTE(u_chr_a, r_chr_a, `VDC_OFS_CHR_A, `VDC_RST_CHR_A, `VDC_MSK_CHR_A)
  `VDC_BYTE(u_chr_b, r_chr_b, `VDC_OFS_CHR_B, `VDC_RST_CHR_B, `VDC_MSK_CHR_B)
  `VDC_BYTE(u_av_hi, r_av_hi, `VDC_OFS_AV_HI, `VDC_RST_AV_HI, `VDC_MSK_AV_HI)

  // low byte of the start position waits here until the upper byte lands
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      av_lo_stage_q <= `VDC_RST_AV_LO;
    end else if (wr_stb && (sub_q == `VDC_OFS_AV_LO)) begin
      av_lo_stage_q <= shift_q;
    end
  end

  // read mux is registered; the address is stable long before the ack clock ends
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
    end else begin
      case (sub_q)
        `VDC_OFS_ROUTE: rdata_q <= r_route;
        `VDC_OFS_GAIN: rdata_q <= r_gain;
        `VDC_OFS_STD: rdata_q <= r_std;
        `VDC_OFS_PWR: rdata_q <= r_pwr;
        `VDC_OFS_MASK: rdata_q <= r_mask;
        `VDC_OFS_KILL: rdata_q <= r_kill;
        `VDC_OFS_LUMA_A: rdata_q <= r_luma_a;
        `VDC_OFS_LUMA_B: rdata_q <= r_luma_b;
        `VDC_OFS_TRAP: rdata_q <= r_trap;
        `VDC_OFS_BRIGHT: rdata_q <= r_bright;
        `VDC_OFS_CONTR: rdata_q <= r_contr;
        `VDC_OFS_SAT: rdata_q <= r_sat;
        `VDC_OFS_HUE: rdata_q <= r_hue;
        `VDC_OFS_CHR_A: rdata_q <= r_chr_a;
        `VDC_OFS_CHR_B: rdata_q <= r_chr_b;
        `VDC_OFS_AV_LO: rdata_q <= av_lo_stage_q;
        `VDC_OFS_AV_HI: rdata_q <= r_av_hi;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // datapath settings
  // ---------------------------------------------------------------
  wire is_component;
  wire is_composite;
  assign is_component = r_route[7];
  assign is_composite = (r_route[7:6] == 2'b00);

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      std_prev_q <= `VDC_RST_STD;
      av_init_q <= 1'b0;
      input_routing_out <= 8'h00;
      auto_luma_gain_out <= 1'b0;
      auto_chroma_gain_out <= 1'b0;
      frontend_gain_freeze_out <= 1'b0;
      standard_out <= 3'h0;
      autoswitch_on_out <= 1'b0;
      standard_reserved_out <= 1'b0;
      settings_reinit_out <= 1'b0;
      proc_clock_slow_out <= 1'b0;
      adc_power_down_out <= 1'b0;
      autodetect_mask_out <= 7'h00;
      color_kill_auto_out <= 1'b0;
      color_kill_force_out <= 1'b0;
      color_kill_threshold_out <= 5'h00;
      pedestal_present_out <= 1'b0;
      raw_vbi_out <= 1'b0;
      luma_delay_out <= 4'h0;
      luma_filter_out <= 2'h0;
      peaking_gain_out <= 2'h0;
      trap_filter_out <= 2'h0;
      brightness_out <= 8'h00;
      contrast_out <= 8'h00;
      saturation_out <= 8'h00;
      hue_out <= 8'h00;
      chroma_gain_mode_out <= 2'h0;
      color_pll_reset_out <= 1'b0;
      chroma_comb_on_out <= 1'b0;
      pal_comp_out <= 1'b0;
      wideband_chroma_lowpass_out <= 1'b0;
      chroma_notch_out <= 2'h0;
      active_video_start_out <= 10'h000;
      active_video_flag_vblank_off_out <= 1'b0;
    end else begin
      input_routing_out <= r_route;
      // gain bits drive only the front end; level controls are separate
      auto_luma_gain_out <= r_gain[0];
      frontend_gain_freeze_out <= ~r_gain[0];
      auto_chroma_gain_out <= r_gain[1] & r_gain[0];
      standard_out <= r_std[2:0];
      autoswitch_on_out <= (r_std[2:0] == 3'h0);
      standard_reserved_out <= is_component & (r_std[2:0] > 3'h2);
      std_prev_q <= r_std;
      av_init_q <= 1'b1;
      settings_reinit_out <= (std_prev_q != r_std);
      // registers stay intact in power save; the datapath clock slows and the ADC powers down
      proc_clock_slow_out <= r_pwr[0];
      adc_power_down_out <= r_pwr[0];
      autodetect_mask_out <= r_mask[6:0];
      color_kill_auto_out <= (r_kill[6:5] == 2'b00);
      color_kill_force_out <= (r_kill[6:5] == 2'b10);
      color_kill_threshold_out <= r_kill[4:0];
      pedestal_present_out <= ~r_luma_a[6];
      raw_vbi_out <= r_luma_a[4] & embedded_format_in;
      // reserved delay code falls back to zero delay
      luma_delay_out <= (r_luma_a[3:0] == 4'h7) ? 4'h0 : r_luma_a[3:0];
      luma_filter_out <= (r_luma_b[7:6] == 2'b11) ? 2'b00 : r_luma_b[7:6];
      peaking_gain_out <= r_luma_b[3:2];
      trap_filter_out <= r_trap[1:0];
      brightness_out <= r_bright;
      contrast_out <= r_contr;
      saturation_out <= r_sat;
      hue_out <= is_component ? 8'h00 : r_hue;
      chroma_gain_mode_out <= (r_chr_a[1:0] == 2'b01) ? 2'b00 : r_chr_a[1:0];
      color_pll_reset_out <= r_chr_a[4];
      chroma_comb_on_out <= ~r_chr_a[3] & is_composite;
      pal_comp_out <= r_chr_b[3];
      wideband_chroma_lowpass_out <= r_chr_b[2];
      chroma_notch_out <= r_chr_b[1:0];
      if (wr_stb && (sub_q == `VDC_OFS_AV_HI)) begin
        active_video_start_out <= {shift_q[1:0], av_lo_stage_q};
      end else if (!av_init_q) begin
        // default position loads once after reset, never from a lone low byte
        active_video_start_out <= {r_av_hi[1:0], av_lo_stage_q};
      end
      active_video_flag_vblank_off_out <= r_av_hi[5];
    end
  end
endmodule // vdc_ctrl_regs
`default_nettype wire

// >>> common/vdc_regs.vh
// register map, field masks, reset values and host port constants of the decoder control bank
`ifndef VDC_REGS_VH
`define VDC_REGS_VH

`define VDC_DEV_ADDR 7'h5c
`define VDC_OFS_ROUTE 8'h00
`define VDC_OFS_GAIN 8'h01
`define VDC_OFS_STD 8'h02
`define VDC_OFS_PWR 8'h03
`define VDC_OFS_MASK 8'h04
`define VDC_OFS_KILL 8'h05
`define VDC_OFS_LUMA_A 8'h06
`define VDC_OFS_LUMA_B 8'h07
`define VDC_OFS_TRAP 8'h08
`define VDC_OFS_BRIGHT 8'h09
`define VDC_OFS_CONTR 8'h0a
`define VDC_OFS_SAT 8'h0b
`define VDC_OFS_HUE 8'h0c
`define VDC_OFS_CHR_A 8'h0d
`define VDC_OFS_CHR_B 8'h0e
`define VDC_OFS_AV_LO 8'h16
`define VDC_OFS_AV_HI 8'h17

`define VDC_RST_ROUTE 8'h00
`define VDC_RST_GAIN 8'h0f
`define VDC_RST_STD 8'h00
`define VDC_RST_PWR 8'h00
`define VDC_RST_MASK 8'h23
`define VDC_RST_KILL 8'h10
`define VDC_RST_LUMA_A 8'h00
`define VDC_RST_LUMA_B 8'h00
`define VDC_RST_TRAP 8'h02
`define VDC_RST_LEVEL 8'h80
`define VDC_RST_HUE 8'h00
`define VDC_RST_CHR_A 8'h00
`define VDC_RST_CHR_B 8'h0e
`define VDC_RST_AV_LO 8'h55
`define VDC_RST_AV_HI 8'h00

`define VDC_MSK_FULL 8'hff
`define VDC_MSK_GAIN 8'h0f
`define VDC_MSK_STD 8'h07
`define VDC_MSK_PWR 8'h01
`define VDC_MSK_MASK 8'h7f
`define VDC_MSK_KILL 8'h7f
`define VDC_MSK_LUMA_A 8'h5f
`define VDC_MSK_LUMA_B 8'hcc
`define VDC_MSK_TRAP 8'h03
`define VDC_MSK_CHR_A 8'h1b
`define VDC_MSK_CHR_B 8'h0f
`define VDC_MSK_AV_HI 8'h23

`endif

// >>> verilog/vdc_byte_reg.v
// one host-writable byte with reset value and writable-bit mask
`timescale 1ns/1ns
`default_nettype none
module vdc_byte_reg #(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] WR_MASK = 8'hff
) (
  input wire clock_in,
  input wire rst_n_in,
  input wire we_in,
  input wire [7:0] data_in,
  output wire [7:0] value_out
);
  reg [7:0] value_q;

  // reserved bits never store, so they read back zero
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      value_q <= RESET_VAL & WR_MASK;
    end else if (we_in) begin
      value_q <= data_in & WR_MASK;
    end
  end

  assign value_out = value_q;
endmodule // vdc_byte_reg
`default_nettype wire

// >>> verilog/vdc_pin_edge.v
// level history and edge pulses of one serial port pin
`timescale 1ns/1ns
`default_nettype none
module vdc_pin_edge (
  input wire clock_in,
  input wire rst_n_in,
  input wire pin_in,
  output wire level_out,
  output wire rise_out,
  output wire fall_out
);
  reg cur_q;
  reg prev_q;

  // idle bus is high, so reset to high to avoid a false edge
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      cur_q <= pin_in;
      prev_q <= cur_q;
    end
  end

  assign level_out = cur_q;
  assign rise_out = cur_q & ~prev_q;
  assign fall_out = ~cur_q & prev_q;
endmodule // vdc_pin_edge
`default_nettype wire

// >>> dv/vdc_ctrl_regs_checker.sv
// concurrent checks on the decoder control bank outputs
`timescale 1ns/1ns
`default_nettype none
module vdc_ctrl_regs_checker (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic embedded_format_in,
  input wire logic [7:0] input_routing_out,
  input wire logic auto_luma_gain_out,
  input wire logic auto_chroma_gain_out,
  input wire logic frontend_gain_freeze_out,
  input wire logic [2:0] standard_out,
  input wire logic autoswitch_on_out,
  input wire logic standard_reserved_out,
  input wire logic settings_reinit_out,
  input wire logic proc_clock_slow_out,
  input wire logic adc_power_down_out,
  input wire logic color_kill_auto_out,
  input wire logic color_kill_force_out,
  input wire logic raw_vbi_out,
  input wire logic [3:0] luma_delay_out,
  input wire logic [7:0] hue_out,
  input wire logic chroma_comb_on_out
);
  // ----------------------------------------
  // output relations
  // ----------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  chroma_needs_luma_a:
    assert property (auto_chroma_gain_out |-> auto_luma_gain_out) else $error("chroma auto alone");
  freeze_manual_a:
    assert property ($past(rst_n_in) |-> frontend_gain_freeze_out != auto_luma_gain_out)
      else $error("freeze wrong");
  autoswitch_code_a:
    assert property ($past(rst_n_in) |-> autoswitch_on_out == (standard_out == 3'h0))
      else $error("autoswitch wrong");
  component_reserved_a:
    assert property (standard_reserved_out == (input_routing_out[7] && standard_out > 3'h2))
      else $error("reserved standard flag wrong");
  reinit_on_change_a:
    assert property ($changed(standard_out) |-> (settings_reinit_out || $past(settings_reinit_out))
      or (##1 settings_reinit_out)) else $error("standard change without reinit");
  reinit_pulse_a:
    assert property (settings_reinit_out |=> !settings_reinit_out) else $error("reinit too long");
  power_save_pair_a:
    assert property (proc_clock_slow_out == adc_power_down_out) else $error("power save split");
  kill_mode_a:
    assert property (!(color_kill_auto_out && color_kill_force_out)) else $error("kill modes both");
  raw_vbi_format_a:
    assert property (!embedded_format_in |=> !raw_vbi_out) else $error("raw vbi outside format");
  luma_delay_code_a:
    assert property (luma_delay_out != 4'h7) else $error("reserved luma delay");
  hue_component_a:
    assert property (input_routing_out[7] |-> hue_out == 8'h00) else $error("hue on component");
  comb_composite_a:
    assert property (chroma_comb_on_out |-> input_routing_out[7:6] == 2'b00)
      else $error("comb off composite");
  reinit_c: cover property (settings_reinit_out);
  raw_vbi_c: cover property (raw_vbi_out);
  reserved_std_c: cover property (standard_reserved_out);
endmodule // vdc_ctrl_regs_checker

bind vdc_ctrl_regs vdc_ctrl_regs_checker u_checker (
  .clock_in, .rst_n_in, .embedded_format_in, .input_routing_out, .auto_luma_gain_out,
  .auto_chroma_gain_out, .frontend_gain_freeze_out, .standard_out, .autoswitch_on_out,
  .standard_reserved_out, .settings_reinit_out, .proc_clock_slow_out, .adc_power_down_out,
  .color_kill_auto_out, .color_kill_force_out, .raw_vbi_out, .luma_delay_out, .hue_out,
  .chroma_comb_on_out
);
`default_nettype wire

// >>> dv/vdc_host_model.sv
// behavioural host controller for the two-wire port; it only pulls data low
`timescale 1ns/1ns
`default_nettype none
`include "vdc_regs.vh"
module vdc_host_model (
  input wire logic clock_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // ----------------------------------------
  // bit and frame helpers
  // ----------------------------------------
  // at least eight clocks per scl phase (ten when low), twice the minimum, keeps the two clock pin lag clear
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low_out <= ~b;
    tick(8);
    scl_out <= 1'b1;
    tick(8);
    r = sda_in;
    scl_out <= 1'b0;
    tick(2);
  endtask
  task automatic start_cond();
    sda_low_out <= 1'b0;
    scl_out <= 1'b1;
    tick(8);
    sda_low_out <= 1'b1;
    tick(8);
    scl_out <= 1'b0;
    tick(2);
  endtask
  task automatic stop_cond();
    sda_low_out <= 1'b1;
    tick(8);
    scl_out <= 1'b1;
    tick(8);
    sda_low_out <= 1'b0;
    tick(8);
  endtask
  // ninth bit always released: device ack on writes, host nack on single reads
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic write_regs(input logic [6:0] dev, input logic [7:0] ofs, input logic [15:0] d,
    input int n, output logic ok);
    logic [7:0] rx;
    logic a;
    start_cond();
    byte_io({dev, 1'b0}, rx, ok);
    if (ok) begin
      byte_io(ofs, rx, a);
      ok = a;
      for (int i = 0; i < n; i++) begin
        byte_io(d[8*i +: 8], rx, a);
        ok = ok & a;
      end
    end
    stop_cond();
  endtask
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    logic a;
    write_regs(`VDC_DEV_ADDR, ofs, 16'h0000, 0, ok);
    start_cond();
    byte_io({`VDC_DEV_ADDR, 1'b1}, d, a);
    ok = ok & a;
    byte_io(8'hff, d, a);
    stop_cond();
  endtask
endmodule // vdc_host_model
`default_nettype wire

// >>> dv/test_video_decoder_control_regs.sv
// self-checking bench for the decoder control register bank
`timescale 1ns/1ns
`default_nettype none
`include "vdc_regs.vh"
module test_video_decoder_control_regs;
  // ----------------------------------------
  // clock, reset, wiring
  // ----------------------------------------
  localparam logic [7:0] RV [17] = '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h23, 8'h10, 8'h00, 8'h00,
    8'h02, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h0e, 8'h55, 8'h00};
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic embedded_format_in = 1'b1;
  int mismatches = 0;
  int check_count = 0;
  int reinit_seen = 0;
  wire logic scl, host_sda_low, sda_line, sda_out, sda_oe_n_out, auto_luma_gain_out;
  wire logic auto_chroma_gain_out, frontend_gain_freeze_out, autoswitch_on_out;
  wire logic standard_reserved_out, settings_reinit_out, proc_clock_slow_out, adc_power_down_out;
  wire logic color_kill_auto_out, color_kill_force_out, pedestal_present_out, raw_vbi_out;
  wire logic color_pll_reset_out, chroma_comb_on_out, pal_comp_out, wideband_chroma_lowpass_out;
  wire logic active_video_flag_vblank_off_out;
  wire logic [1:0] luma_filter_out, peaking_gain_out, trap_filter_out, chroma_gain_mode_out;
  wire logic [1:0] chroma_notch_out;
  wire logic [2:0] standard_out;
  wire logic [3:0] luma_delay_out;
  wire logic [4:0] color_kill_threshold_out;
  wire logic [6:0] autodetect_mask_out;
  wire logic [7:0] input_routing_out, brightness_out, contrast_out, saturation_out, hue_out;
  wire logic [9:0] active_video_start_out;
  // pulled-up line: either party may only pull it low
  assign sda_line = !host_sda_low && (sda_oe_n_out || sda_out);
  initial forever #50 clock_in = ~clock_in;
  always @(posedge clock_in) if (settings_reinit_out === 1'b1) reinit_seen++;
  vdc_ctrl_regs DUT (
    .clock_in, .rst_n_in, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n_out,
    .embedded_format_in, .input_routing_out, .auto_luma_gain_out, .auto_chroma_gain_out,
    .frontend_gain_freeze_out, .standard_out, .autoswitch_on_out, .standard_reserved_out,
    .settings_reinit_out, .proc_clock_slow_out, .adc_power_down_out, .autodetect_mask_out,
    .color_kill_auto_out, .color_kill_force_out, .color_kill_threshold_out, .pedestal_present_out,
    .raw_vbi_out, .luma_delay_out, .luma_filter_out, .peaking_gain_out, .trap_filter_out,
    .brightness_out, .contrast_out, .saturation_out, .hue_out, .chroma_gain_mode_out,
    .color_pll_reset_out, .chroma_comb_on_out, .pal_comp_out, .wideband_chroma_lowpass_out,
    .chroma_notch_out, .active_video_start_out, .active_video_flag_vblank_off_out
  );
  vdc_host_model host (.clock_in, .sda_in(sda_line), .scl_out(scl), .sda_low_out(host_sda_low));
  // ----------------------------------------
  // helpers and scenarios
  // ----------------------------------------
  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic ok;
    host.write_regs(`VDC_DEV_ADDR, ofs, {8'h00, d}, 1, ok);
    chk(ok, 1'b1);
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.read_reg(ofs, d, ok);
    chk({ok, d}, {1'b1, e});
  endtask
  task automatic t_reset();
    for (int i = 0; i < 17; i++) rd(i < 15 ? i[7:0] : 8'h07 + i[7:0], RV[i]);
    chk({brightness_out, 6'h00, active_video_start_out}, 24'h800055);
  endtask
  task automatic t_gain();
    for (int v = 12; v < 16; v++) begin
      wr(8'h01, v[7:0]);
      chk({auto_luma_gain_out, auto_chroma_gain_out, frontend_gain_freeze_out},
        {v[0], v[1] & v[0], ~v[0]});
      chk({brightness_out, contrast_out}, 16'h8080);
    end
  endtask
  task automatic t_std();
    int n;
    for (int c = 1; c < 9; c++) begin
      n = reinit_seen;
      wr(8'h02, c[7:0] & 8'h07);
      chk({standard_out, autoswitch_on_out, standard_reserved_out}, {c[2:0], c == 8, 1'b0});
      chk(16'(reinit_seen - n), 16'h0001);
    end
    wr(8'h00, 8'h94);
    chk(input_routing_out, 8'h94);
    wr(8'h02, 8'h03);
    chk(standard_reserved_out, 1'b1);
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h00);
  endtask
  task automatic t_power_mask();
    wr(8'h03, 8'h01);
    chk({proc_clock_slow_out, adc_power_down_out}, 2'b11);
    rd(8'h01, 8'h0f);
    wr(8'h03, 8'h00);
    chk({proc_clock_slow_out, adc_power_down_out}, 2'b00);
    wr(8'h04, 8'h7f);
    chk(autodetect_mask_out, 7'h7f);
    wr(8'h04, 8'h23);
    chk(autodetect_mask_out, 7'h23);
  endtask
  task automatic t_kill_luma();
    for (int k = 0; k < 4; k++) begin
      wr(8'h05, {1'b0, k[1:0], 5'h1f});
      chk({color_kill_auto_out, color_kill_force_out, color_kill_threshold_out},
        {k == 0, k == 2, 5'h1f});
      wr(8'h07, {k[1:0], 2'b00, ~k[1:0], 2'b00});
      chk({luma_filter_out, peaking_gain_out}, {(k == 3 ? 2'b00 : k[1:0]), ~k[1:0]});
      wr(8'h08, k[7:0]);
      chk(trap_filter_out, k[1:0]);
    end
    wr(8'h06, 8'h58);
    chk({pedestal_present_out, raw_vbi_out, luma_delay_out}, 6'b01_1000);
    embedded_format_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk(raw_vbi_out, 1'b0);
    embedded_format_in <= 1'b1;
    wr(8'h06, 8'h07);
    chk({pedestal_present_out, raw_vbi_out, luma_delay_out}, 6'b10_0000);
  endtask
  task automatic t_levels_chroma();
    wr(8'h09, 8'hff);
    wr(8'h0a, 8'h00);
    wr(8'h0b, 8'h01);
    wr(8'h0c, 8'h80);
    chk({brightness_out, contrast_out}, 16'hff00);
    chk({saturation_out, hue_out}, 16'h0180);
    wr(8'h00, 8'h95);
    chk({hue_out, chroma_comb_on_out}, 9'h000);
    wr(8'h00, 8'h00);
    for (int g = 0; g < 4; g++) begin
      wr(8'h0d, {3'b000, g[0], g[1], 1'b0, g[1:0]});
      chk({color_pll_reset_out, chroma_comb_on_out, chroma_gain_mode_out},
        {g[0], ~g[1], (g == 1 ? 2'b00 : g[1:0])});
    end
    wr(8'h0e, 8'h0b);
    chk({pal_comp_out, wideband_chroma_lowpass_out, chroma_notch_out}, 4'b1011);
  endtask
  task automatic t_active_video_flag_refuse();
    logic ok;
    wr(8'h16, 8'h34);
    chk({active_video_flag_vblank_off_out, active_video_start_out}, 11'h055);
    wr(8'h17, 8'h22);
    chk({active_video_flag_vblank_off_out, active_video_start_out}, 11'h634);
    host.write_regs(`VDC_DEV_ADDR, 8'h16, 16'h0312, 2, ok);
    chk({ok, active_video_flag_vblank_off_out, active_video_start_out}, 12'h b12);
    rd(8'h17, 8'h03);
    host.write_regs(`VDC_DEV_ADDR ^ 7'h01, 8'h09, 16'h0055, 1, ok);
    chk({ok, brightness_out}, 9'h0ff);
    rd(8'h0f, 8'h00);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_gain();
    t_std();
    t_power_mask();
    t_kill_luma();
    t_levels_chroma();
    t_active_video_flag_refuse();
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge clock_in);
    mismatches++;
    finish_test();
  end
endmodule // test_video_decoder_control_regs
`default_nettype wire
